// ---- core/tws_pkg.sv ----
// Constants and types for the two-wire slave core
// Summary of operation
// - Works with masters at 100 and 400 kHz
// - Transmit prepare sets hidden flag; unprepare clears it
// - Receive prepare sets hidden flag; unprepare clears it
// - Slave stretches clock; master waits it out
// - Stays in low-power wait until a start condition
// - Channels read and write RAM without processor
// - Stopped only after memory accesses finished
// - Detect stop and restart conditions
// - Leave disabled only on enable, then wait
// - Raise begun and stopped events; accept stop task
// - Acknowledge matching address; read or write event
// - Stretch clock until matching prepare when unprepared
// - Transmit entry raises event, clears transmit flag
// - Over-read sends over-read character, raises error
package tws_pkg;
	localparam int ADDR_W  = 7;
	localparam int CNT_W   = 14;
	localparam int PTR_W   = 32;
	localparam int BIT_MSB = 7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	typedef enum logic [3:0] {
		TWS_DISABLED = 4'h0,
		TWS_IDLE     = 4'h1,
		TWS_ADDR     = 4'h3,
		TWS_ADDR_ACK = 4'h2,
		TWS_WAIT     = 4'h6,
		TWS_TX       = 4'h7,
		TWS_TX_ACK   = 4'h5,
		TWS_RX       = 4'h4,
		TWS_RX_ACK   = 4'hc,
		TWS_IGNORE   = 4'hd,
		TWS_DRAIN    = 4'hf
	} tws_state_type;
endpackage

// ---- core/tws_mem_if.sv ----
// Memory channel signals between the core and its memory port
`timescale 1ns/1ps
`default_nettype none
interface tws_mem_if;
	logic                    rd_req;
	logic [tws_pkg::PTR_W-1:0] rd_addr;
	logic                    rd_done;
	logic [7:0]              rd_data;
	logic                    wr_req;
	logic [tws_pkg::PTR_W-1:0] wr_addr;
	logic [7:0]              wr_data;
	logic                    wr_done;
	modport core (output rd_req, rd_addr, wr_req, wr_addr, wr_data, input rd_done, rd_data, wr_done);
	modport port (input rd_req, rd_addr, wr_req, wr_addr, wr_data, output rd_done, rd_data, wr_done);
endinterface
`default_nettype wire

// ---- core/tws_mem_port.sv ----
// Memory port: one outstanding byte access at a time to RAM, shared by both channels
`timescale 1ns/1ps
`default_nettype none
module tws_mem_port (
	// Clock and reset
	input  wire logic                      ref_clk,
	input  wire logic                      srst,
	// Core side
	tws_mem_if.port                        mem,
	// RAM side
	output logic                           ram_req,
	output logic                           ram_we,
	output logic [tws_pkg::PTR_W-1:0]      ram_addr,
	output logic [7:0]                     ram_wdata,
	input  wire logic                      ram_ack,
	input  wire logic [7:0]                ram_rdata
);
	logic busy_wr;

	// Issue one access and hold it until acknowledged
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			ram_req   <= 1'b0;
			ram_we    <= 1'b0;
			ram_addr  <= '0;
			ram_wdata <= 8'h00;
			busy_wr   <= 1'b0;
		end else if (ram_req) begin
			if (ram_ack) ram_req <= 1'b0;
		end else if (mem.wr_req) begin
			ram_req   <= 1'b1;
			ram_we    <= 1'b1;
			busy_wr   <= 1'b1;
			ram_addr  <= mem.wr_addr;
			ram_wdata <= mem.wr_data;
		end else if (mem.rd_req) begin
			ram_req  <= 1'b1;
			ram_we   <= 1'b0;
			busy_wr  <= 1'b0;
			ram_addr <= mem.rd_addr;
		end
	end

	// Completion pulses back to the core
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			mem.rd_done <= 1'b0;
			mem.wr_done <= 1'b0;
			mem.rd_data <= 8'h00;
		end else begin
			mem.rd_done <= ram_req && ram_ack && !busy_wr;
			mem.wr_done <= ram_req && ram_ack && busy_wr;
			if (ram_req && ram_ack && !busy_wr) mem.rd_data <= ram_rdata;
		end
	end
endmodule
`default_nettype wire

// ---- core/tws_core.sv ----
// Two-wire slave core with memory reader and writer channels
`timescale 1ns/1ps
`default_nettype none
module tws_core (
	// Clock and reset
	input  wire logic                         ref_clk,
	input  wire logic                         srst,
	// Bus pins; output enable low means drive low
	input  wire logic                         scl_in,
	output logic                              scl_oe_n,
	input  wire logic                         sda_in,
	output logic                              sda_oe_n,
	// Configuration
	input  wire logic                         enable,
	input  wire logic [tws_pkg::ADDR_W-1:0]   listen_addr0,
	input  wire logic [tws_pkg::ADDR_W-1:0]   listen_addr1,
	input  wire logic [1:0]                   listen_en,
	input  wire logic [7:0]                   over_read_character,
	input  wire logic [tws_pkg::PTR_W-1:0]    tx_ptr,
	input  wire logic [tws_pkg::CNT_W-1:0]    tx_maxcnt,
	input  wire logic [tws_pkg::PTR_W-1:0]    rx_ptr,
	input  wire logic [tws_pkg::CNT_W-1:0]    rx_maxcnt,
	// Tasks
	input  wire logic                         transmit_prepare_trigger,
	input  wire logic                         receive_prepare_trigger,
	input  wire logic                         stop_trigger,
	// Events and status
	output logic                              read_event,
	output logic                              write_event,
	output logic                              transmit_begun_event,
	output logic                              receive_begun_event,
	output logic                              stopped_event,
	output logic                              error_event,
	output logic [tws_pkg::CNT_W-1:0]         tx_amount,
	output logic [tws_pkg::CNT_W-1:0]         rx_amount,
	output logic                              sleeping,
	// RAM
	output logic                              ram_req,
	output logic                              ram_we,
	output logic [tws_pkg::PTR_W-1:0]         ram_addr,
	output logic [7:0]                        ram_wdata,
	input  wire logic                         ram_ack,
	input  wire logic [7:0]                   ram_rdata
);
	tws_mem_if                  mem ();
	tws_pkg::tws_state_type     state;
	logic [1:0]                 scl_s;
	logic [1:0]                 sda_s;
	logic                       scl_q;
	logic                       sda_q;
	logic                       tx_prepared;
	logic                       rx_prepared;
	logic [7:0]                 shreg;
	logic [2:0]                 bitn;
	logic                       dir_read;
	logic                       nack_m;
	logic                       overflow;
	logic                       have_byte;
	logic [tws_pkg::PTR_W-1:0]  ptr_l;
	logic [tws_pkg::CNT_W-1:0]  max_l;
	logic [tws_pkg::CNT_W-1:0]  cnt;
	logic                       wr_pend;
	logic                       rd_pend;
	logic                       stop_req;
	logic                       scl_rise;
	logic                       scl_fall;
	logic                       start_c;
	logic                       stop_c;
	logic                       addr_hit;
	logic                       addr_full;

	function automatic logic match(input logic [7:0] b, input logic [6:0] a, input logic en);
		match = en && (b[7:1] == a);
	endfunction

	tws_mem_port u_port (
		.ref_clk   (ref_clk),
		.srst      (srst),
		.mem       (mem.port),
		.ram_req   (ram_req),
		.ram_we    (ram_we),
		.ram_addr  (ram_addr),
		.ram_wdata (ram_wdata),
		.ram_ack   (ram_ack),
		.ram_rdata (ram_rdata)
	);

	// Pin synchronisers and edge history
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_s <= {scl_s[0], scl_in};
			sda_s <= {sda_s[0], sda_in};
			scl_q <= scl_s[1];
			sda_q <= sda_s[1];
		end
	end

	assign scl_rise = scl_s[1] && !scl_q;
	assign scl_fall = !scl_s[1] && scl_q;
	assign start_c  = scl_s[1] && scl_q && sda_q && !sda_s[1];
	assign stop_c   = scl_s[1] && scl_q && !sda_q && sda_s[1];
	assign addr_hit = match(shreg, listen_addr0, listen_en[0]) ||
	                  match(shreg, listen_addr1, listen_en[1]);

	// Hidden prepared flags; a trigger wins over the unprepare
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_prepared <= 1'b0;
			rx_prepared <= 1'b0;
		end else begin
			if (transmit_prepare_trigger) tx_prepared <= 1'b1;
			else if ((state == tws_pkg::TWS_WAIT && dir_read) ||
			         (state == tws_pkg::TWS_DRAIN && !wr_pend && !rd_pend))
				tx_prepared <= 1'b0;
			if (receive_prepare_trigger) rx_prepared <= 1'b1;
			else if ((state == tws_pkg::TWS_WAIT && !dir_read) ||
			         (state == tws_pkg::TWS_DRAIN && !wr_pend && !rd_pend))
				rx_prepared <= 1'b0;
		end
	end

	// Stop task held until the drain begins
	always_ff @(posedge ref_clk) begin
		if (srst) stop_req <= 1'b0;
		else if (state == tws_pkg::TWS_DRAIN || state == tws_pkg::TWS_IDLE ||
		         state == tws_pkg::TWS_DISABLED) stop_req <= 1'b0;
		else if (stop_trigger) stop_req <= 1'b1;
	end

	// Main sequencer; bytes move on the master's clock up to 400 kHz
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state <= tws_pkg::TWS_DISABLED;
			bitn <= 3'h0; shreg <= 8'h00; dir_read <= 1'b0; nack_m <= 1'b0;
			overflow <= 1'b0; have_byte <= 1'b0; ptr_l <= '0; max_l <= '0; cnt <= '0;
			scl_oe_n <= 1'b1; sda_oe_n <= 1'b1; wr_pend <= 1'b0; rd_pend <= 1'b0;
			read_event <= 1'b0; write_event <= 1'b0; transmit_begun_event <= 1'b0;
			receive_begun_event <= 1'b0; stopped_event <= 1'b0; error_event <= 1'b0;
			tx_amount <= '0; rx_amount <= '0; sleeping <= 1'b0;
			mem.rd_req <= 1'b0; mem.wr_req <= 1'b0; mem.rd_addr <= '0;
			mem.wr_addr <= '0; mem.wr_data <= 8'h00;
			addr_full <= 1'b0;
		end else begin
			read_event <= 1'b0; write_event <= 1'b0; transmit_begun_event <= 1'b0;
			receive_begun_event <= 1'b0; stopped_event <= 1'b0; error_event <= 1'b0;
			mem.rd_req <= 1'b0; mem.wr_req <= 1'b0;
			if (mem.rd_done) begin
				rd_pend <= 1'b0; have_byte <= 1'b1;
			end
			if (mem.wr_done) wr_pend <= 1'b0;
			sleeping <= enable && (state == tws_pkg::TWS_IDLE);
			if (!enable) begin
				state <= tws_pkg::TWS_DISABLED; scl_oe_n <= 1'b1; sda_oe_n <= 1'b1;
			end else if ((stop_c || stop_req) && state != tws_pkg::TWS_DISABLED &&
			             state != tws_pkg::TWS_IDLE && state != tws_pkg::TWS_DRAIN) begin
				state <= tws_pkg::TWS_DRAIN; scl_oe_n <= 1'b1; sda_oe_n <= 1'b1;
			end else if (start_c && state != tws_pkg::TWS_DISABLED &&
			             state != tws_pkg::TWS_DRAIN) begin
				state <= tws_pkg::TWS_ADDR; bitn <= 3'h0; sda_oe_n <= 1'b1;
				addr_full <= 1'b0;
			end else begin
				unique case (state)
				tws_pkg::TWS_DISABLED: if (enable) state <= tws_pkg::TWS_IDLE;
				tws_pkg::TWS_IDLE: ;
				tws_pkg::TWS_ADDR: if (scl_rise) begin
					shreg <= {shreg[6:0], sda_s[1]};
					bitn <= bitn + 3'h1;
					addr_full <= (bitn == tws_pkg::BIT_LAST);
				end else if (scl_fall && addr_full) begin
					if (addr_hit) begin
						sda_oe_n <= 1'b0; dir_read <= shreg[0];
						read_event <= shreg[0]; write_event <= !shreg[0];
						state <= tws_pkg::TWS_ADDR_ACK;
					end else state <= tws_pkg::TWS_IGNORE;
				end
				tws_pkg::TWS_ADDR_ACK: if (scl_fall) begin
					sda_oe_n <= 1'b1; scl_oe_n <= 1'b0; state <= tws_pkg::TWS_WAIT;
				end
				tws_pkg::TWS_WAIT: if (dir_read ? tx_prepared : rx_prepared) begin
					ptr_l <= dir_read ? tx_ptr : rx_ptr;
					max_l <= dir_read ? tx_maxcnt : rx_maxcnt;
					cnt <= '0; bitn <= 3'h0; overflow <= 1'b0; have_byte <= 1'b0;
					transmit_begun_event <= dir_read;
					receive_begun_event <= !dir_read;
					if (dir_read) begin
						if (tx_maxcnt != '0) begin
							mem.rd_req <= 1'b1; mem.rd_addr <= tx_ptr; rd_pend <= 1'b1;
						end
					end else scl_oe_n <= 1'b1;
					state <= dir_read ? tws_pkg::TWS_TX : tws_pkg::TWS_RX;
				end
				tws_pkg::TWS_TX: begin
					if (bitn == 3'h0 && !scl_oe_n) begin
						if (cnt >= max_l) begin
							shreg <= over_read_character; sda_oe_n <= over_read_character[tws_pkg::BIT_MSB];
							scl_oe_n <= 1'b1; overflow <= 1'b1;
							if (!overflow) error_event <= 1'b1;
						end else if (have_byte) begin
							shreg <= mem.rd_data; sda_oe_n <= mem.rd_data[tws_pkg::BIT_MSB];
							scl_oe_n <= 1'b1; have_byte <= 1'b0;
							cnt <= cnt + 1'b1; tx_amount <= cnt + 1'b1;
						end
					end else if (scl_fall) begin
						if (bitn == tws_pkg::BIT_LAST) begin
							sda_oe_n <= 1'b1; state <= tws_pkg::TWS_TX_ACK;
						end else begin
							sda_oe_n <= shreg[6]; shreg <= {shreg[6:0], 1'b0};
						end
						bitn <= bitn + 3'h1;
					end
				end
				tws_pkg::TWS_TX_ACK: if (scl_rise) nack_m <= sda_s[1];
					else if (scl_fall) begin
					if (nack_m) state <= tws_pkg::TWS_IGNORE;
					else begin
						scl_oe_n <= 1'b0; state <= tws_pkg::TWS_TX;
						if (cnt < max_l) begin
							mem.rd_req <= 1'b1; mem.rd_addr <= ptr_l + PTR_EXT(cnt); rd_pend <= 1'b1;
						end
					end
				end
				tws_pkg::TWS_RX: if (scl_rise) begin
					shreg <= {shreg[6:0], sda_s[1]}; bitn <= bitn + 3'h1;
				end else if (scl_fall && bitn == 3'h0) begin
					if (cnt < max_l) begin
						sda_oe_n <= 1'b0; cnt <= cnt + 1'b1; rx_amount <= cnt + 1'b1;
						mem.wr_req <= 1'b1; mem.wr_data <= shreg; wr_pend <= 1'b1;
						mem.wr_addr <= ptr_l + PTR_EXT(cnt);
					end else error_event <= 1'b1;
					state <= tws_pkg::TWS_RX_ACK;
				end
				tws_pkg::TWS_RX_ACK: if (scl_fall) begin
					sda_oe_n <= 1'b1; state <= tws_pkg::TWS_RX;
				end
				tws_pkg::TWS_IGNORE: ;
				tws_pkg::TWS_DRAIN: if (!wr_pend && !rd_pend) begin
					stopped_event <= 1'b1; state <= tws_pkg::TWS_IDLE;
				end
				default: state <= tws_pkg::TWS_IDLE;
				endcase
			end
		end
	end

	function automatic logic [tws_pkg::PTR_W-1:0] PTR_EXT(input logic [tws_pkg::CNT_W-1:0] c);
		PTR_EXT = {{(tws_pkg::PTR_W-tws_pkg::CNT_W){1'b0}}, c};
	endfunction
endmodule
`default_nettype wire

// ---- verif/tws_master_model.sv ----
// Single bus master model with open-drain lines that waits out stretching
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
	// Wire levels
	input  wire logic scl,
	input  wire logic sda,
	// Own drivers, low pulls the line low
	output logic      scl_drv_n,
	output logic      sda_drv_n
);
	// Sole master on the bus, no arbitration is ever attempted
	initial begin
		scl_drv_n = 1'b1;
		sda_drv_n = 1'b1;
	end
	task automatic clk_hi();
		int n;
		n = 0;
		scl_drv_n = 1'b1;
		while (scl !== 1'b1 && n < 2000) begin
			#25;
			n++;
		end
		#100;
	endtask
	task automatic bit_io(input logic b, output logic r);
		#50;
		sda_drv_n = b;
		#50;
		clk_hi();
		r = sda;
		scl_drv_n = 1'b0;
	endtask
	task automatic start();
		#50;
		sda_drv_n = 1'b1;
		#50;
		clk_hi();
		sda_drv_n = 1'b0;
		#100;
		scl_drv_n = 1'b0;
	endtask
	task automatic stop();
		#50;
		sda_drv_n = 1'b0;
		#50;
		clk_hi();
		sda_drv_n = 1'b1;
		#100;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], q[i]);
		bit_io(ack, a);
	endtask
endmodule
`default_nettype wire

// ---- verif/tws_core_asserts.sv ----
// Port checker for the two-wire slave core
`timescale 1ns/1ps
`default_nettype none
module tws_core_asserts (
	// Clock and reset
	input wire logic                      ref_clk,
	input wire logic                      srst,
	// Control and line drivers
	input wire logic                      enable,
	input wire logic                      scl_oe_n,
	input wire logic                      sda_oe_n,
	// Events and status
	input wire logic                      read_event,
	input wire logic                      write_event,
	input wire logic                      transmit_begun_event,
	input wire logic                      stopped_event,
	input wire logic                      sleeping,
	// RAM
	input wire logic                      ram_req,
	input wire logic                      ram_we,
	input wire logic                      ram_ack,
	input wire logic [tws_pkg::PTR_W-1:0] ram_addr
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (srst);
	AST_RST_REL: assert property (disable iff (1'b0) srst |=> scl_oe_n && sda_oe_n && !ram_req)
		else $error("Lines or RAM request held in reset");
	AST_OFF_REL: assert property (!enable |=> scl_oe_n && sda_oe_n && !sleeping)
		else $error("Disabled core drives the bus");
	AST_IDLE_FREE: assert property (sleeping |-> scl_oe_n && sda_oe_n && !ram_req)
		else $error("Active while waiting in low power");
	AST_DIR_ONE: assert property (!(read_event && write_event))
		else $error("Read and write event together");
	AST_ADDR_ACK: assert property (read_event || write_event |-> ##[0:1] !sda_oe_n)
		else $error("Address event without acknowledge");
	AST_TX_FETCH: assert property (transmit_begun_event |-> ##[0:40] ram_req && !ram_we)
		else $error("Transmit began without memory fetch");
	AST_RAM_HOLD: assert property (ram_req && !ram_ack |=> ram_req && $stable(ram_addr) && $stable(ram_we))
		else $error("RAM request dropped or changed before ack");
	AST_STOP_DONE: assert property (stopped_event |-> !ram_req ##1 !stopped_event)
		else $error("Stopped with memory access open or too long");
	AST_STOP_IDLE: assert property (stopped_event |-> ##[0:3] sleeping)
		else $error("No return to idle after stop");
endmodule
bind tws_core tws_core_asserts u_asserts (
	.ref_clk(ref_clk), .srst(srst), .enable(enable), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n),
	.read_event(read_event), .write_event(write_event),
	.transmit_begun_event(transmit_begun_event), .stopped_event(stopped_event),
	.sleeping(sleeping), .ram_req(ram_req), .ram_we(ram_we), .ram_ack(ram_ack),
	.ram_addr(ram_addr)
);
`default_nettype wire

// ---- verif/tws_core_bench.sv ----
// Self-checking bench for the two-wire slave core
`timescale 1ns/1ps
`default_nettype none
module tws_core_bench;
	localparam logic [6:0] ADDR_A  = 7'h2a;
	localparam logic [6:0] ADDR_B  = 7'h51;
	localparam logic [7:0] ORC_VAL = 8'he7;
	logic                      ref_clk = 1'b0;
	logic                      srst = 1'b1;
	logic                      enable = 1'b0;
	logic [2:0]                trig_vec = 3'h0;
	logic                      ram_ack = 1'b0;
	logic [7:0]                ram_rdata = 8'h00;
	logic [tws_pkg::PTR_W-1:0] tx_ptr = 32'h100;
	logic [tws_pkg::PTR_W-1:0] rx_ptr = 32'h200;
	logic [tws_pkg::CNT_W-1:0] tx_max = 14'h1;
	logic [tws_pkg::CNT_W-1:0] rx_max = 14'h2;
	logic [tws_pkg::PTR_W-1:0] ram_addr;
	logic [7:0]                ram_wdata, q;
	wire logic [5:0]           ev;
	logic [tws_pkg::CNT_W-1:0] tx_amt, rx_amt;
	logic                      scl_oe_n, sda_oe_n, m_scl_n, m_sda_n, ram_req, ram_we, a, sleeping;
	wire logic                 scl = scl_oe_n & m_scl_n;
	wire logic                 sda = sda_oe_n & m_sda_n;
	logic [7:0]                wd [3] = '{8'hc3, 8'h3c, 8'h96};
	logic [7:0]                wq [$];
	logic [tws_pkg::PTR_W-1:0] aq [$];
	int                        n_ev [6];
	int                        fails = 0;
	int                        num_checks = 0;
	always #12.5 ref_clk = ~ref_clk;
	tws_master_model m (.scl(scl), .sda(sda), .scl_drv_n(m_scl_n), .sda_drv_n(m_sda_n));
	tws_core u_dut (
		.ref_clk(ref_clk), .srst(srst), .scl_in(scl), .scl_oe_n(scl_oe_n), .sda_in(sda),
		.sda_oe_n(sda_oe_n), .enable(enable), .listen_addr0(ADDR_A), .listen_addr1(ADDR_B),
		.listen_en(2'h3), .over_read_character(ORC_VAL), .tx_ptr(tx_ptr), .tx_maxcnt(tx_max),
		.rx_ptr(rx_ptr), .rx_maxcnt(rx_max), .transmit_prepare_trigger(trig_vec[0]),
		.receive_prepare_trigger(trig_vec[1]), .stop_trigger(trig_vec[2]),
		.read_event(ev[0]), .write_event(ev[1]), .transmit_begun_event(ev[2]),
		.receive_begun_event(ev[3]), .stopped_event(ev[4]), .error_event(ev[5]),
		.tx_amount(tx_amt), .rx_amount(rx_amt), .sleeping(sleeping), .ram_req(ram_req),
		.ram_we(ram_we),
		.ram_addr(ram_addr), .ram_wdata(ram_wdata), .ram_ack(ram_ack), .ram_rdata(ram_rdata)
	);
	// Event counters and a one-cycle RAM
	always @(posedge ref_clk) begin
		for (int i = 0; i < 6; i++)
			if (ev[i] === 1'b1)
				n_ev[i]++;
		ram_ack <= ram_req && !ram_ack;
		ram_rdata <= ram_addr[7:0] ^ 8'h5a;
		if (ram_req && !ram_ack && ram_we) begin
			wq.push_back(ram_wdata);
			aq.push_back(ram_addr);
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic trig(input logic [2:0] t);
		@(posedge ref_clk);
		trig_vec <= t;
		@(posedge ref_clk);
		trig_vec <= 3'h0;
	endtask
	task automatic wait_stop(input int t);
		int n;
		n = 0;
		while (n_ev[4] < t && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		fails++;
		conclude();
	end
	initial begin
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		enable <= 1'b1;
		#1 chk(sleeping, 1'b0);
		repeat (4) @(posedge ref_clk);
		#1 chk(sleeping, 1'b1);
		$display("Test enable done");
		trig(3'h3);
		m.start();
		m.xfer({ADDR_A, 1'b0}, 1'b1, q, a);
		chk(a, 1'b0);
		chk(n_ev[1], 1);
		foreach (wd[i]) begin
			m.xfer(wd[i], 1'b1, q, a);
			chk(a, i > 1);
		end
		chk(n_ev[3], 1);
		chk(n_ev[5], 1);
		chk(wq.size(), 2);
		chk({wq[0], wq[1]}, 16'hc33c);
		chk(aq[1], rx_ptr + 1);
		chk(rx_amt, rx_max);
		m.stop();
		wait_stop(1);
		chk(n_ev[4], 1);
		$display("Test write done");
		m.start();
		m.xfer({ADDR_B, 1'b1}, 1'b1, q, a);
		chk(a, 1'b0);
		chk(n_ev[0], 1);
		fork
			m.xfer(8'hff, 1'b0, q, a);
			begin
				repeat (40) @(posedge ref_clk);
				chk(scl, 1'b0);
				chk(n_ev[2], 0);
				trig(3'h1);
			end
		join
		chk(n_ev[2], 1);
		chk(q, tx_ptr[7:0] ^ 8'h5a);
		m.xfer(8'hff, 1'b1, q, a);
		chk(q, ORC_VAL);
		chk(n_ev[5], 2);
		chk(tx_amt, tx_max);
		$display("Test read done");
		m.start();
		m.xfer({ADDR_A ^ 7'h01, 1'b0}, 1'b1, q, a);
		chk(a, 1'b1);
		trig(3'h2);
		m.start();
		m.xfer({ADDR_A, 1'b0}, 1'b1, q, a);
		chk(a, 1'b0);
		repeat (40) @(posedge ref_clk);
		chk(n_ev[3], 2);
		trig(3'h4);
		wait_stop(2);
		chk(n_ev[4], 2);
		m.stop();
		$display("Test restart done");
		conclude();
	end
endmodule
`default_nettype wire
